// File: core/flash_nvm_ctrl.sv
// internal memory decode with remap, flash controller and nonvolatile control bits
// What this block does
// - sram at its fixed base always; also at zero once remap has run
// - boot rom decoded at its fixed base at all times
// - flash decoded at its fixed base at all times
// - flash also aliased at zero before remap, per boot bit 2
// - setting boot bit 2 boots from flash; erase pin clears it
// - 256-byte page write buffer filled by 32-bit bus writes
// - flash goes to standby whenever nothing reads or writes it
// - apb interface for wait states, commands, status and interrupt enables
// - two 32-bit prefetch words serve sequential 16-bit fetches
// - one controller per plane; read one plane while other programs
// - lock regions of 64 pages, 16 lock bits per controller
// - program or erase of a locked region aborts and interrupts
// - set-lock and clear-lock commands change region protection
// - erase pin clears every lock bit
// - security bit refuses debug and fast port flash accesses
// - security only set by command; cleared by erase pin plus full erase
// - boot bit 0 enables the brownout detector; erase pin clears it
// - boot bit 1 enables brownout reset; erase pin clears it
// - eight factory calibration bits are read-only and survive erase
// - busy lasts 6 ms, 3 ms or 15 ms per operation
// - test pin and port lines zero and one high enter fast mode
// - erase pin is recognised only after 200 ms of assertion
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module flash_nvm_ctrl #(
	parameter int unsigned PROG_ERASE_CYC = nvm_pkg::PROG_ERASE_CYC,
	parameter int unsigned PROG_CYC       = nvm_pkg::PROG_CYC,
	parameter int unsigned FULL_ERASE_CYC = nvm_pkg::FULL_ERASE_CYC,
	parameter int unsigned DEBOUNCE_CYC   = nvm_pkg::DEBOUNCE_CYC
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata_ff,
	output var  logic                         pready_ff,
	output var  logic                         pslverr_ff,
	input  wire logic                         bus_valid,
	input  wire logic                         bus_write,
	input  wire logic                         bus_fetch16,
	input  wire logic                         bus_dbg,
	input  wire logic [31:0]                  bus_addr,
	input  wire logic [31:0]                  bus_wdata,
	output var  logic                         hit_sram_ff,
	output var  logic                         hit_rom_ff,
	output var  logic                         hit_flash_ff,
	output var  logic                         bus_abort_ff,
	output var  logic                         bus_busy_ff,
	output var  logic                         pf_hit_ff,
	output var  logic [31:0]                  bus_rdata_ff,
	output var  logic                         flash_rd_ff,
	output var  logic [19:0]                  flash_addr_ff,
	input  wire logic                         flash_rvalid,
	input  wire logic [63:0]                  flash_rdata,
	output var  logic                         flash_standby_ff,
	output var  logic [1:0]                   plane_busy_ff,
	output var  logic [3:0]                   flash_op_ff,
	output var  logic [nvm_pkg::PAGE_W-1:0]   flash_page_ff,
	input  wire logic [nvm_pkg::WBUF_AW-1:0]  wbuf_raddr,
	output var  logic [31:0]                  wbuf_rdata_ff,
	input  wire logic                         erase_pin,
	input  wire logic                         test_mode_pin,
	input  wire logic                         port_a_line_zero,
	input  wire logic                         port_a_line_one,
	input  wire logic [7:0]                   cal_fuse,
	output var  logic                         fast_prog_mode_ff,
	output var  logic                         brownout_en_ff,
	output var  logic                         brownout_rst_ff,
	output var  logic [1:0]                   wait_states_ff,
	output var  logic                         irq_ff
);
	import nvm_pkg::*;

	logic [3:0]          sync1_ff;
	logic [3:0]          sync2_ff;
	logic [CNT_W-1:0]    deb_cnt_ff;
	logic                erase_fired_ff;
	logic                remap_ff;
	logic [2:0]          gpbit_ff;
	logic [NUM_LOCK-1:0] lock_ff;
	logic                security_ff;
	logic                armed_ff;
	logic                ie_done_ff;
	logic                ie_lock_ff;
	logic                done_ff;
	logic                lockerr_ff;
	logic                full_run_ff;
	logic [7:0]          cal_ff;
	logic                cal_loaded_ff;
	logic                rd_pend_ff;
	logic                pf_valid_ff;
	logic [16:0]         pf_tag_ff;
	logic [63:0]         pf_data_ff;
	logic [CNT_W-1:0]    busy_cnt_ff [0:1];
	logic                run_ok;

	// area match on address bits 27:20 inside the 256 Mbyte internal space
	function automatic logic area_is(input logic [31:0] addr, input logic [31:0] base);
		area_is = (addr[31:28] == 4'h0) && (addr[27:20] == base[27:20]);
	endfunction

	// lock region of a page: 64 pages per region
	function automatic logic [4:0] lock_idx(input logic [PAGE_W-1:0] page);
		lock_idx = page[PAGE_W-1:6];
	endfunction

	// pin synchronisers: erase, test, port line zero, port line one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= {port_a_line_one, port_a_line_zero, test_mode_pin, erase_pin};
			sync2_ff <= sync1_ff;
		end
	end

	// erase pin debounce
	wire erase_s   = sync2_ff[0];
	wire deb_full  = (deb_cnt_ff == CNT_W'(DEBOUNCE_CYC - 1));
	wire erase_hit = erase_s && deb_full && !erase_fired_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_cnt_ff     <= '0;
			erase_fired_ff <= 1'b0;
		end else begin
			deb_cnt_ff     <= (!erase_s) ? '0 : (deb_full ? deb_cnt_ff : deb_cnt_ff + 1'b1);
			erase_fired_ff <= erase_s && (erase_fired_ff || deb_full);
		end
	end

	// address decode for bus masters
	wire [1:0] busy_w     = {busy_cnt_ff[1] != '0, busy_cnt_ff[0] != '0};
	wire       at_zero    = area_is(bus_addr, BOOT_BASE);
	wire       is_sram    = area_is(bus_addr, SRAM_BASE) || (at_zero && remap_ff);
	wire       is_rom     = area_is(bus_addr, ROM_BASE) || (at_zero && !remap_ff && !gpbit_ff[2]);
	wire       is_flash   = area_is(bus_addr, FLASH_BASE) || (at_zero && !remap_ff && gpbit_ff[2]);
	wire       fast_mode  = sync2_ff[1] && sync2_ff[2] && sync2_ff[3];
	wire       sec_block  = security_ff && (bus_dbg || fast_prog_mode_ff) && is_flash;
	wire       hit_busy   = is_flash && busy_w[bus_addr[18]];
	wire       pf_hit     = bus_valid && is_flash && bus_fetch16 && !bus_write && !sec_block
	                        && pf_valid_ff && (pf_tag_ff == bus_addr[19:3]);
	wire       do_abort   = bus_valid && (!(is_flash || is_sram || is_rom) || sec_block);
	wire       flash_go   = bus_valid && is_flash && !sec_block && !hit_busy;
	wire       flash_rdgo = flash_go && !bus_write && !pf_hit;
	wire       wbuf_wr    = flash_go && bus_write;

	// registered decode outputs toward the bus masters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_sram_ff  <= 1'b0;
			hit_rom_ff   <= 1'b0;
			hit_flash_ff <= 1'b0;
			bus_abort_ff <= 1'b0;
			bus_busy_ff  <= 1'b0;
			pf_hit_ff    <= 1'b0;
		end else begin
			hit_sram_ff  <= bus_valid && is_sram;
			hit_rom_ff   <= bus_valid && is_rom;
			hit_flash_ff <= bus_valid && is_flash && !sec_block;
			bus_abort_ff <= do_abort;
			bus_busy_ff  <= bus_valid && hit_busy && !sec_block;
			pf_hit_ff    <= pf_hit;
		end
	end

	// flash read request and prefetch pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_rd_ff   <= 1'b0;
			flash_addr_ff <= 20'h0;
			rd_pend_ff    <= 1'b0;
			pf_valid_ff   <= 1'b0;
			pf_tag_ff     <= 17'h0;
			pf_data_ff    <= 64'h0;
			bus_rdata_ff  <= 32'h0;
		end else begin
			flash_rd_ff <= flash_rdgo;
			if (flash_go) begin
				flash_addr_ff <= bus_addr[19:0];
			end
			rd_pend_ff <= flash_rdgo || (rd_pend_ff && !flash_rvalid);
			if (flash_rvalid) begin
				pf_valid_ff  <= 1'b1;
				pf_tag_ff    <= flash_addr_ff[19:3];
				pf_data_ff   <= flash_rdata;
				bus_rdata_ff <= flash_addr_ff[2] ? flash_rdata[63:32] : flash_rdata[31:0];
			end else begin
				if (run_ok) begin
					pf_valid_ff <= 1'b0;
				end
				if (pf_hit) begin
					bus_rdata_ff <= bus_addr[2] ? pf_data_ff[63:32] : pf_data_ff[31:0];
				end
			end
		end
	end

	// standby whenever the array is idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_standby_ff <= 1'b1;
		end else begin
			flash_standby_ff <= !(flash_rdgo || wbuf_wr || rd_pend_ff || (busy_w != 2'h0));
		end
	end

	// page write buffer
	wbuf_mem u_wbuf (
		.pclk     (pclk),
		.wr_en    (wbuf_wr),
		.waddr    (bus_addr[WBUF_AW+1:2]),
		.wdata    (bus_wdata),
		.raddr    (wbuf_raddr),
		.rdata_ff (wbuf_rdata_ff)
	);

	// apb decode
	wire apb_setup = psel && !penable;
	wire apb_acc   = psel && penable && pready_ff;
	wire apb_wr    = apb_acc && pwrite;
	wire mapped    = (paddr == OFF_MODE) || (paddr == OFF_CMD) || (paddr == OFF_STAT)
	                 || (paddr == OFF_LOCK) || (paddr == OFF_REMAP);
	wire stat_rd   = apb_acc && !pwrite && (paddr == OFF_STAT);

	// command decode
	wire                cmd_wr    = apb_wr && (paddr == OFF_CMD);
	wire [3:0]          cmd_code  = pwdata[CMD_CODE_LSB +: 4];
	wire [PAGE_W-1:0]   cmd_page  = pwdata[CMD_ARG_LSB +: PAGE_W];
	wire                cmd_plane = cmd_page[PAGE_W-1];
	wire                is_prog   = (cmd_code == CMD_PROG_ERASE) || (cmd_code == CMD_PROG);
	wire                is_full   = (cmd_code == CMD_FULL_ERASE);
	wire                cmd_free  = is_full ? (busy_w == 2'h0) : !busy_w[cmd_plane];
	wire                lock_hit  = is_prog ? lock_ff[lock_idx(cmd_page)] : (is_full && (lock_ff != '0));
	wire                cmd_take  = cmd_wr && cmd_free;
	wire                lock_abort = cmd_take && lock_hit;
	assign run_ok = cmd_take && !lock_hit;
	wire                timed     = is_prog || is_full;
	wire [1:0]          fin       = {busy_cnt_ff[1] == CNT_W'(1), busy_cnt_ff[0] == CNT_W'(1)};
	wire                sec_clear = fin[0] && full_run_ff && armed_ff;
	wire [CNT_W-1:0]    start_cyc = (cmd_code == CMD_PROG_ERASE) ? CNT_W'(PROG_ERASE_CYC)
	                              : (cmd_code == CMD_PROG) ? CNT_W'(PROG_CYC) : CNT_W'(FULL_ERASE_CYC);

	// per-plane busy counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				busy_cnt_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (run_ok && timed && (is_full || (cmd_plane == i[0]))) begin
					busy_cnt_ff[i] <= start_cyc;
				end else if (busy_cnt_ff[i] != '0) begin
					busy_cnt_ff[i] <= busy_cnt_ff[i] - 1'b1;
				end
			end
		end
	end

	// operation shown to the array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			plane_busy_ff <= 2'h0;
			flash_op_ff   <= 4'h0;
			flash_page_ff <= '0;
			full_run_ff   <= 1'b0;
		end else begin
			plane_busy_ff <= busy_w;
			if (run_ok && timed) begin
				flash_op_ff   <= cmd_code;
				flash_page_ff <= cmd_page;
			end
			full_run_ff <= (run_ok && is_full) || (full_run_ff && !fin[0]);
		end
	end

	// lock bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_ff <= LOCK_RST;
		end else if (erase_hit) begin
			lock_ff <= '0;
		end else if (run_ok && (cmd_code == CMD_SET_LOCK)) begin
			lock_ff[lock_idx(cmd_page)] <= 1'b1;
		end else if (run_ok && (cmd_code == CMD_CLR_LOCK)) begin
			lock_ff[lock_idx(cmd_page)] <= 1'b0;
		end
	end

	// general-purpose nonvolatile bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpbit_ff <= GPBIT_RST;
		end else if (erase_hit) begin
			gpbit_ff <= 3'h0;
		end else if (run_ok && (cmd_code == CMD_SET_GP) && (cmd_page[1:0] != 2'h3)) begin
			gpbit_ff[cmd_page[1:0]] <= 1'b1;
		end else if (run_ok && (cmd_code == CMD_CLR_GP) && (cmd_page[1:0] != 2'h3)) begin
			gpbit_ff[cmd_page[1:0]] <= 1'b0;
		end
	end

	// security bit and erase arming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			security_ff <= SEC_RST;
			armed_ff    <= 1'b0;
		end else begin
			if (run_ok && (cmd_code == CMD_SET_SEC)) begin
				security_ff <= 1'b1;
			end else if (sec_clear) begin
				security_ff <= 1'b0;
			end
			armed_ff <= erase_hit || (armed_ff && !sec_clear);
		end
	end

	// status flags: a new event wins over the clear by read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff    <= 1'b0;
			lockerr_ff <= 1'b0;
			irq_ff     <= 1'b0;
		end else begin
			done_ff    <= (run_ok && !timed) || (fin != 2'h0) || (done_ff && !stat_rd);
			lockerr_ff <= lock_abort || (lockerr_ff && !stat_rd);
			irq_ff     <= (done_ff && ie_done_ff) || (lockerr_ff && ie_lock_ff);
		end
	end

	// mode, remap, pin-driven and boot-bit-driven outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_states_ff    <= WS_RST;
			ie_done_ff        <= 1'b0;
			ie_lock_ff        <= 1'b0;
			remap_ff          <= 1'b0;
			fast_prog_mode_ff <= 1'b0;
			brownout_en_ff    <= 1'b0;
			brownout_rst_ff   <= 1'b0;
		end else begin
			if (apb_wr && (paddr == OFF_MODE)) begin
				wait_states_ff <= pwdata[MODE_WS_LSB +: 2];
				ie_done_ff     <= pwdata[MODE_IE_DONE];
				ie_lock_ff     <= pwdata[MODE_IE_LOCK];
			end
			if (apb_wr && (paddr == OFF_REMAP) && pwdata[0]) begin
				remap_ff <= 1'b1;
			end
			fast_prog_mode_ff <= fast_mode;
			brownout_en_ff    <= gpbit_ff[0];
			brownout_rst_ff   <= gpbit_ff[1];
		end
	end

	// factory calibration captured once after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_ff        <= 8'h0;
			cal_loaded_ff <= 1'b0;
		end else if (!cal_loaded_ff) begin
			cal_ff        <= cal_fuse;
			cal_loaded_ff <= 1'b1;
		end
	end

	// apb read data
	wire [31:0] mode_word = {22'h0, ie_lock_ff, ie_done_ff, 6'h0, wait_states_ff};
	wire [31:0] stat_word = {6'h0, fast_prog_mode_ff, remap_ff, cal_ff, 5'h0, gpbit_ff,
	                         3'h0, security_ff, 2'h0, lockerr_ff, busy_w == 2'h0};
	wire [31:0] rd_word   = (paddr == OFF_MODE) ? mode_word
	                      : (paddr == OFF_STAT) ? stat_word
	                      : (paddr == OFF_LOCK) ? lock_ff
	                      : (paddr == OFF_REMAP) ? {31'h0, remap_ff} : 32'h0;

	// zero-wait apb slave: answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= apb_setup;
			pslverr_ff <= apb_setup && !mapped;
			if (apb_setup && !pwrite) begin
				prdata_ff <= rd_word;
			end
		end
	end

	// checks
	abort_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_valid && (bus_addr[31:22] != 10'h0) |=> bus_abort_ff && !hit_flash_ff)
		else $error("unmapped access not aborted");
	sram_alias_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_valid && at_zero && remap_ff |=> hit_sram_ff && !hit_rom_ff)
		else $error("sram not aliased at zero after remap");
	rom_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_valid && area_is(bus_addr, ROM_BASE) |=> hit_rom_ff)
		else $error("rom not decoded at its base");
	boot_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_valid && at_zero && !remap_ff && gpbit_ff[2] && !security_ff |=> hit_flash_ff && !hit_rom_ff)
		else $error("flash not at zero with boot bit set");
	lock_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		lock_abort |=> lockerr_ff && $stable(flash_op_ff) ##1 irq_ff || !ie_lock_ff)
		else $error("locked command not aborted");
	erase_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		erase_hit |=> lock_ff == '0 && gpbit_ff == 3'h0 && $stable(cal_ff) ##1 !brownout_en_ff)
		else $error("erase pin did not clear nonvolatile bits");
	sec_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
		bus_valid && is_flash && security_ff && bus_dbg |=> bus_abort_ff && !flash_rd_ff)
		else $error("secured flash access not refused");
	prog_time_a: assert property (@(posedge pclk) disable iff (!presetn)
		run_ok && (cmd_code == CMD_PROG) && !cmd_plane |=> busy_cnt_ff[0] == CNT_W'(PROG_CYC))
		else $error("program busy time wrong");
	pf_serve_a: assert property (@(posedge pclk) disable iff (!presetn)
		pf_hit |=> pf_hit_ff && !flash_rd_ff)
		else $error("prefetch hit went to the array");
	standby_a: assert property (@(posedge pclk) disable iff (!presetn)
		!bus_valid && !rd_pend_ff && busy_w == 2'h0 |=> flash_standby_ff)
		else $error("idle flash not in standby");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready_ff ##1 !pready_ff)
		else $error("apb answer timing wrong");
endmodule
`default_nettype wire

// File: core/nvm_pkg.sv
// constants, offsets and command codes for the flash nonvolatile control block
package nvm_pkg;
	// internal memory areas, 1 Mbyte each, selected by address bits 27:20
	localparam logic [31:0] BOOT_BASE  = 32'h0000_0000;
	localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
	localparam logic [31:0] SRAM_BASE  = 32'h0020_0000;
	localparam logic [31:0] ROM_BASE   = 32'h0030_0000;

	// apb register byte offsets
	localparam logic [7:0] OFF_MODE   = 8'h00;
	localparam logic [7:0] OFF_CMD    = 8'h04;
	localparam logic [7:0] OFF_STAT   = 8'h08;
	localparam logic [7:0] OFF_LOCK   = 8'h0C;
	localparam logic [7:0] OFF_REMAP  = 8'h10;

	// field positions
	localparam int MODE_WS_LSB  = 0;
	localparam int MODE_IE_DONE = 8;
	localparam int MODE_IE_LOCK = 9;
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_ARG_LSB  = 8;
	localparam int STAT_READY   = 0;
	localparam int STAT_LOCKE   = 1;
	localparam int STAT_SEC     = 4;
	localparam int STAT_GP_LSB  = 8;
	localparam int STAT_CAL_LSB = 16;
	localparam int STAT_REMAP   = 24;
	localparam int STAT_FAST    = 25;

	// reset values of the nonvolatile image
	localparam logic [1:0]  WS_RST    = 2'h0;
	localparam logic [2:0]  GPBIT_RST = 3'h0;
	localparam logic [31:0] LOCK_RST  = 32'h0;
	localparam logic        SEC_RST   = 1'b0;

	// sizes
	localparam int PAGE_W    = 11;
	localparam int NUM_LOCK  = 32;
	localparam int WBUF_AW   = 6;
	localparam int WBUF_DEPTH = 64;
	localparam int CNT_W     = 24;

	// command codes
	typedef enum logic [3:0] {
		CMD_PROG_ERASE = 4'h1,
		CMD_PROG       = 4'h2,
		CMD_SET_LOCK   = 4'h3,
		CMD_CLR_LOCK   = 4'h4,
		CMD_SET_GP     = 4'h5,
		CMD_CLR_GP     = 4'h6,
		CMD_SET_SEC    = 4'h7,
		CMD_FULL_ERASE = 4'h8
	} cmd_e;

	// timing
	localparam int unsigned CLK_MHZ         = 10;
	localparam int unsigned T_PROG_ERASE_US = 6000;
	localparam int unsigned T_PROG_US       = 3000;
	localparam int unsigned T_FULL_ERASE_US = 15000;
	localparam int unsigned T_DEBOUNCE_US   = 200000;
	localparam int unsigned T_ERASE_HOLD_MS = 220;
	localparam int unsigned PROG_ERASE_CYC  = T_PROG_ERASE_US * CLK_MHZ;
	localparam int unsigned PROG_CYC        = T_PROG_US * CLK_MHZ;
	localparam int unsigned FULL_ERASE_CYC  = T_FULL_ERASE_US * CLK_MHZ;
	localparam int unsigned DEBOUNCE_CYC    = T_DEBOUNCE_US * CLK_MHZ;
endpackage

// File: core/wbuf_mem.sv
// page write buffer memory, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module wbuf_mem (
	input  wire logic                       pclk,
	input  wire logic                       wr_en,
	input  wire logic [nvm_pkg::WBUF_AW-1:0] waddr,
	input  wire logic [31:0]                wdata,
	input  wire logic [nvm_pkg::WBUF_AW-1:0] raddr,
	output var  logic [31:0]                rdata_ff
);
	import nvm_pkg::*;

	logic [31:0] mem [0:WBUF_DEPTH-1];

	// storage has no reset, read data is registered
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end
endmodule
`default_nettype wire

// File: test/flash_array_model.sv
// flash array model: answers each read strobe after a fixed latency
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
	parameter int LAT = 3
) (
	input  wire logic        pclk,
	input  wire logic        rd,
	input  wire logic [19:0] addr,
	output var  logic        rvalid,
	output var  logic [63:0] rdata
);
	int          cnt = 0;
	logic [19:0] a_ff = 20'h0;
	initial rvalid = 1'b0;
	initial rdata = 64'h0;
	// between answers the data lines toggle so stale data never looks valid
	always @(posedge pclk) begin
		rvalid <= (cnt == 1);
		rdata <= (cnt == 1) ? {12'hD00, a_ff, 12'hC00, a_ff} : ~rdata;
		cnt <= rd ? LAT : (cnt > 0 ? cnt - 1 : 0);
		if (rd)
			a_ff <= addr;
	end
endmodule
`default_nettype wire

// File: test/memory_map_flash_nvm_control_test.sv
// testbench for the memory decode and flash nonvolatile control block
`timescale 1ns/1ps
`default_nettype none
module memory_map_flash_nvm_control_test;
	import nvm_pkg::*;
	typedef struct {logic [31:0] a; logic [6:0] e;} row_s;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic        bus_valid = 1'b0, bus_write = 1'b0, bus_fetch16 = 1'b0, bus_dbg = 1'b0, erase_pin = 1'b0;
	logic        test_mode_pin = 1'b0, port_a_line_zero = 1'b0, port_a_line_one = 1'b0;
	logic [7:0]  paddr = 8'h00, cal_fuse = 8'h5A;
	logic [31:0] pwdata = 32'h0, bus_addr = 32'h0, bus_wdata = 32'h0, r, prdata_ff, bus_rdata_ff, wbuf_rdata_ff;
	logic [5:0]  wbuf_raddr = 6'h00;
	logic        pready_ff, pslverr_ff, hit_sram_ff, hit_rom_ff, hit_flash_ff, bus_abort_ff, bus_busy_ff, pf_hit_ff;
	logic        flash_rd_ff, flash_rvalid, flash_standby_ff, fast_prog_mode_ff, brownout_en_ff, brownout_rst_ff, irq_ff;
	logic [19:0] flash_addr_ff;
	logic [63:0] flash_rdata;
	logic [1:0]  plane_busy_ff, wait_states_ff;
	logic [3:0]  flash_op_ff;
	logic [10:0] flash_page_ff;
	int          fail_count = 0, comparisons = 0;
	// decode rows: address and {sram, rom, flash, abort, busy, read strobe, prefetch hit}
	row_s rows[6] = '{'{32'h0, 7'h20}, '{32'h0010_0000, 7'h12}, '{32'h002F_FFFC, 7'h40},
		'{32'h003F_FFFC, 7'h20}, '{32'h0040_0000, 7'h08}, '{32'h0FFF_FFFC, 7'h08}};

	flash_nvm_ctrl #(.PROG_ERASE_CYC(20), .PROG_CYC(10), .FULL_ERASE_CYC(40), .DEBOUNCE_CYC(8)) i_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff,
		.bus_valid, .bus_write, .bus_fetch16, .bus_dbg, .bus_addr, .bus_wdata, .hit_sram_ff, .hit_rom_ff,
		.hit_flash_ff, .bus_abort_ff, .bus_busy_ff, .pf_hit_ff, .bus_rdata_ff, .flash_rd_ff, .flash_addr_ff,
		.flash_rvalid, .flash_rdata, .flash_standby_ff, .plane_busy_ff, .flash_op_ff, .flash_page_ff,
		.wbuf_raddr, .wbuf_rdata_ff, .erase_pin, .test_mode_pin, .port_a_line_zero, .port_a_line_one,
		.cal_fuse, .fast_prog_mode_ff, .brownout_en_ff, .brownout_rst_ff, .wait_states_ff, .irq_ff);
	flash_array_model #(.LAT(3)) i_array (.pclk, .rd(flash_rd_ff), .addr(flash_addr_ff),
		.rvalid(flash_rvalid), .rdata(flash_rdata));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, entered and left right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_ff !== 1'b1 && n < 50);
		chk(pready_ff, 1'b1);
		r = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask

	// one system bus access, then the registered answer is compared under a mask
	task automatic acc(input logic [31:0] a, input logic w, f, g, input logic [6:0] e, m);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_write <= w;
		bus_fetch16 <= f;
		bus_dbg <= g;
		@(posedge pclk) bus_valid <= 1'b0;
		@(posedge pclk);
		chk({hit_sram_ff, hit_rom_ff, hit_flash_ff, bus_abort_ff, bus_busy_ff, flash_rd_ff, pf_hit_ff} & m, e & m);
	endtask

	task automatic end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// main sequence: table, then hand-written cases
	initial begin
		repeat (8) @(posedge pclk);
		chk(flash_standby_ff, 1'b1);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
			acc(rows[i].a, 1'b0, 1'b0, 1'b0, rows[i].e, 7'h7F);
		rd(OFF_STAT, 32'hFFFF_FFFF, 32'h005A_0001);
		rd(8'h14, 32'hFFFF_FFFF, 32'h0);
		chk(err, 1'b1);
		wr(OFF_MODE, 32'h0000_0303);
		rd(OFF_MODE, 32'h0000_0303, 32'h0000_0303);
		chk(wait_states_ff, 2'h3);
		for (int i = 0; i < 3; i++)
			wr(OFF_CMD, 32'h0000_0005 | (i << 8));
		wr(OFF_CMD, 32'h0000_0006);
		@(posedge pclk);
		chk({brownout_rst_ff, brownout_en_ff}, 2'h2);
		acc(32'h0, 1'b0, 1'b0, 1'b0, 7'h10, 7'h7D);
		wr(OFF_CMD, 32'h0000_4003);
		rd(OFF_LOCK, 32'hFFFF_FFFF, 32'h0000_0002);
		rd(OFF_STAT, 32'h2, 32'h0);
		wr(OFF_CMD, 32'h0000_4002);
		@(posedge pclk);
		chk(irq_ff, 1'b1);
		rd(OFF_STAT, 32'h3, 32'h3);
		rd(OFF_STAT, 32'h2, 32'h0);
		wr(OFF_CMD, 32'h0000_4004);
		rd(OFF_LOCK, 32'hFFFF_FFFF, 32'h0);
		wr(OFF_CMD, 32'h0000_4102);
		rd(OFF_STAT, 32'h1, 32'h0);
		chk({flash_op_ff, flash_page_ff, plane_busy_ff}, {4'h2, 11'h041, 2'h1});
		acc(32'h0014_0000, 1'b0, 1'b0, 1'b0, 7'h12, 7'h7F);
		acc(32'h0010_0000, 1'b0, 1'b0, 1'b0, 7'h04, 7'h6F);
		repeat (10) @(posedge pclk);
		rd(OFF_STAT, 32'h1, 32'h1);
		wr(OFF_CMD, 32'h0007_C003);
		wr(OFF_CMD, 32'h0000_0007);
		rd(OFF_STAT, 32'h10, 32'h10);
		acc(32'h0010_0000, 1'b0, 1'b0, 1'b1, 7'h08, 7'h6F);
		test_mode_pin <= 1'b1;
		port_a_line_zero <= 1'b1;
		port_a_line_one <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(fast_prog_mode_ff, 1'b1);
		acc(32'h0010_0000, 1'b0, 1'b0, 1'b0, 7'h08, 7'h6F);
		test_mode_pin <= 1'b0;
		port_a_line_zero <= 1'b0;
		port_a_line_one <= 1'b0;
		erase_pin <= 1'b1;
		repeat (20) @(posedge pclk);
		erase_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		rd(OFF_LOCK, 32'hFFFF_FFFF, 32'h0);
		rd(OFF_STAT, 32'h00FF_0710, 32'h005A_0010);
		chk({brownout_rst_ff, brownout_en_ff}, 2'h0);
		acc(32'h0, 1'b0, 1'b0, 1'b0, 7'h20, 7'h7F);
		wr(OFF_CMD, 32'h0000_0008);
		rd(OFF_STAT, 32'h1, 32'h0);
		repeat (45) @(posedge pclk);
		rd(OFF_STAT, 32'h11, 32'h01);
		acc(32'h0010_0000, 1'b0, 1'b0, 1'b1, 7'h12, 7'h7F);
		wr(OFF_REMAP, 32'h0000_0001);
		acc(32'h0, 1'b0, 1'b0, 1'b0, 7'h40, 7'h7F);
		bus_wdata <= 32'h1234_5678;
		acc(32'h0010_0008, 1'b1, 1'b0, 1'b0, 7'h10, 7'h7F);
		wbuf_raddr <= 6'h02;
		repeat (2) @(posedge pclk);
		chk(wbuf_rdata_ff, 32'h1234_5678);
		acc(32'h0010_0010, 1'b0, 1'b0, 1'b0, 7'h12, 7'h7F);
		chk(flash_standby_ff, 1'b0);
		repeat (6) @(posedge pclk);
		chk(flash_standby_ff, 1'b1);
		acc(32'h0010_0014, 1'b0, 1'b1, 1'b0, 7'h11, 7'h6F);
		chk(bus_rdata_ff, 32'hD000_0010);
		// mid-run reset: mode and remap return to their reset state
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(wait_states_ff, 2'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(32'h0, 1'b0, 1'b0, 1'b0, 7'h20, 7'h7F);
		end_sim();
	end

	// watchdog against a hang
	initial begin
		repeat (3000) @(posedge pclk);
		fail_count++;
		end_sim();
	end
endmodule
`default_nettype wire
